// ### hw/locf_pkg.sv
// shared constants and types for the loop one control fields block
package locf_pkg;

    // =========================================================
    // bus geometry
    localparam int APB_AW = 12;
    localparam int APB_DW = 32;

    // =========================================================
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL_A = 8'h38;
    localparam logic [7:0] IDX_CTRL_B = 8'h39;
    localparam logic [7:0] IDX_STATUS = 8'h70;

    // =========================================================
    // loop_one_control_a fields
    localparam int POST_DIV_SEL_LSB = 2;
    localparam int POST_DIV_SEL_W = 3;
    localparam int SYNC_EN_BIT = 1;
    localparam int POWERDOWN_BIT = 0;
    localparam logic [2:0] RST_POST_DIV_SEL = 3'h7;
    localparam logic RST_SYNC_EN = 1'b1;
    localparam logic RST_POWERDOWN = 1'b0;

    // =========================================================
    // loop_one_control_b fields
    localparam int SPARE_BIT = 5;
    localparam int DOUBLER_BIT = 4;
    localparam int CP_CODE_LSB = 0;
    localparam int CP_CODE_W = 4;
    localparam logic RST_SPARE = 1'b0;
    localparam logic RST_DOUBLER = 1'b1;
    localparam logic [3:0] RST_CP_CODE = 4'h8;

    // =========================================================
    // status fields
    localparam int ST_LOOP_ON_BIT = 0;
    localparam int ST_CAL_BUSY_BIT = 1;
    localparam int ST_CAL_DONE_BIT = 2;
    localparam int ST_SYNC_PIN_BIT = 3;

    // =========================================================
    // decoded values at reset, and the charge pump code map
    localparam logic [3:0] RST_POST_DIV_VAL = 4'h8;
    localparam logic [4:0] RST_CP_STEPS = 5'h10;
    localparam logic [3:0] CP_CODE_MAX_STEP = 4'h7;
    localparam logic [3:0] CP_CODE_BOOST = 4'h8;
    localparam logic [4:0] CP_BOOST_STEPS = 5'h10;

    // =========================================================
    // calibration sequencer states
    typedef enum logic [1:0] {
        CAL_OFF,
        CAL_KICK,
        CAL_WAIT,
        CAL_RUN
    } locf_cal_state_t;

endpackage

// ### hw/locf_cal_if.sv
// control and status between register file and calibration sequencer
`timescale 1ns/1ps
`default_nettype none
interface locf_cal_if;
    logic powerdown;
    logic cal_done_lvl;
    logic loop_enable;
    logic cal_reset;
    logic cal_start;
    logic cal_busy;
    logic cal_locked;

    modport ctl (
        output powerdown,
        output cal_done_lvl,
        input loop_enable,
        input cal_reset,
        input cal_start,
        input cal_busy,
        input cal_locked
    );

    modport seq (
        input powerdown,
        input cal_done_lvl,
        output loop_enable,
        output cal_reset,
        output cal_start,
        output cal_busy,
        output cal_locked
    );
endinterface
`default_nettype wire

// ### hw/locf_cal_seq.sv
// loop enable and calibration restart sequencer
`timescale 1ns/1ps
`default_nettype none
module locf_cal_seq (
    input wire logic clk, // system clock
    input wire logic rst_n, // synchronised reset, active low
    locf_cal_if.seq cal // powerdown in, loop controls out
);
    import locf_pkg::*;

    locf_cal_state_t state_r;
    locf_cal_state_t state_nxt;

    // =========================================================
    // next state
    // reset lands in off, so a clear powerdown bit starts the loop by itself
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            CAL_OFF: begin
                if (!cal.powerdown) begin
                    state_nxt = CAL_KICK;
                end
            end
            CAL_KICK: begin
                state_nxt = cal.powerdown ? CAL_OFF : CAL_WAIT;
            end
            CAL_WAIT: begin
                if (cal.powerdown) begin
                    state_nxt = CAL_OFF;
                end else if (cal.cal_done_lvl) begin
                    state_nxt = CAL_RUN;
                end
            end
            CAL_RUN: begin
                if (cal.powerdown) begin
                    state_nxt = CAL_OFF;
                end
            end
            default: begin
                state_nxt = CAL_OFF;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= CAL_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    // =========================================================
    // outputs decoded from state
    // calibration held in reset
    assign cal.cal_reset = (state_r == CAL_OFF);
    assign cal.loop_enable = (state_r != CAL_OFF);
    assign cal.cal_start = (state_r == CAL_KICK);
    assign cal.cal_busy = (state_r == CAL_KICK) || (state_r == CAL_WAIT);
    assign cal.cal_locked = (state_r == CAL_RUN);
endmodule
`default_nettype wire

// ### hw/locf_top.sv
// loop one control fields: apb registers, sync gating, loop enable and calibration
// Notes on behaviour
// - with loop_sync_enable at 1 (its reset value) a sync event resynchronises the loop's channels.
// - after hardware reset the loop is enabled and calibrated only if loop_powerdown, reset 0, is 0.
// - setting loop_powerdown to 1 disables the loop and holds its calibration in reset.
// - clearing loop_powerdown re-enables the loop and restarts calibration with no other command.
// - reference_doubler_enable at 1, its reset value, turns the primary input doubler on.
// - the 4-bit charge_pump_gain_code, reset 0x8, gives 0.4 mA steps for 1 to 7 and 6.4 mA for 8.
// - post_divider_select at bits 4:2, reset 0x7, gives divide 2 for codes 0,1 and 3 to 8 for 2 to 7.
`timescale 1ns/1ps
`default_nettype none
module locf_top #(
    parameter int ADDR_WIDTH = locf_pkg::APB_AW
) (
    input wire logic SYS_CLK, // 200 MHz system clock
    input wire logic RESETN, // asynchronous reset, active low
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb access phase
    input wire logic PWRITE, // apb direction, 1 = write
    input wire logic [ADDR_WIDTH-1:0] PADDR, // apb byte address
    input wire logic [locf_pkg::APB_DW-1:0] PWDATA, // apb write data
    input wire logic [3:0] PSTRB, // apb byte strobes
    output logic [locf_pkg::APB_DW-1:0] PRDATA, // apb read data
    output logic PREADY, // apb ready
    output logic PSLVERR, // apb error on unmapped address
    input wire logic SYNC_EVENT, // sync pin, rising edge is an event
    input wire logic CAL_DONE, // calibration finished, from the loop
    output logic CHANNEL_RESYNC, // one-cycle resync pulse to loop channels
    output logic LOOP_ENABLE, // loop powered and running
    output logic CAL_RESET, // calibration circuit held in reset
    output logic CAL_START, // one-cycle calibration start pulse
    output logic REF_DOUBLER_EN, // primary input doubler on
    output logic [3:0] CP_CODE, // charge pump gain code
    output logic [4:0] CP_CURRENT_STEPS, // pump current in 0.4 mA units
    output logic [3:0] POST_DIV_VALUE // post divider ratio, 2 to 8
);
    import locf_pkg::*;

    // =========================================================
    // parameter check
    // upper-bit test needs at least one bit above the word index
    if (ADDR_WIDTH < 11) begin : g_aw_check
        $error("locf_top: ADDR_WIDTH must be at least 11");
    end

    // =========================================================
    // reset release
    // entry is immediate, exit waits two edges so no flop sees a ragged release
    logic [1:0] rst_sync_r;
    logic rst_n;

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_r[1];

    // =========================================================
    // pin synchronisers; a level counts once stages two and three agree
    // stage one feeds only stage two, so a metastable sample never reaches logic
    localparam int NPIN = 2;
    localparam int PIN_SYNC = 0;
    localparam int PIN_DONE = 1;

    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_lvl;

    assign pin_raw = {CAL_DONE, SYNC_EVENT};

    for (genvar gi = 0; gi < NPIN; gi++) begin : g_pin
        logic s1_r;
        logic s2_r;
        logic s3_r;
        logic lvl_r;

        always_ff @(posedge SYS_CLK or negedge rst_n) begin
            if (!rst_n) begin
                s1_r <= 1'b0;
                s2_r <= 1'b0;
                s3_r <= 1'b0;
                lvl_r <= 1'b0;
            end else begin
                s1_r <= pin_raw[gi];
                s2_r <= s1_r;
                s3_r <= s2_r;
                if (s2_r == s3_r) begin
                    lvl_r <= s3_r;
                end
            end
        end

        assign pin_lvl[gi] = lvl_r;
    end

    // =========================================================
    // field decoders
    function automatic logic [3:0] post_div_of(input logic [2:0] sel);
        // codes 0 and 1 both divide by two
        post_div_of = (sel < 3'h2) ? 4'h2 : ({1'b0, sel} + 4'h1);
    endfunction

    function automatic logic [4:0] cp_steps_of(input logic [3:0] code);
        // undocumented codes leave the pump off rather than guess
        if ((code != 4'h0) && (code <= CP_CODE_MAX_STEP)) begin
            cp_steps_of = {1'b0, code};
        end else if (code == CP_CODE_BOOST) begin
            cp_steps_of = CP_BOOST_STEPS;
        end else begin
            cp_steps_of = 5'h00;
        end
    endfunction

    // =========================================================
    // apb decode
    logic [7:0] word_idx;
    logic aligned;
    logic hit_a;
    logic hit_b;
    logic hit_st;
    logic mapped;
    logic setup_rd;
    logic access;
    logic wr_a;
    logic wr_b;

    // upper address bits must be clear, so aliases of the map never answer
    assign word_idx = PADDR[9:2];
    assign aligned = (PADDR[1:0] == 2'h0) && (PADDR[ADDR_WIDTH-1:10] == '0);
    assign hit_a = aligned && (word_idx == IDX_CTRL_A);
    assign hit_b = aligned && (word_idx == IDX_CTRL_B);
    assign hit_st = aligned && (word_idx == IDX_STATUS);
    assign mapped = hit_a || hit_b || hit_st;
    assign setup_rd = PSEL && !PENABLE && !PWRITE;
    assign access = PSEL && PENABLE;
    // only byte lane zero carries data
    assign wr_a = access && PWRITE && hit_a && PSTRB[0];
    assign wr_b = access && PWRITE && hit_b && PSTRB[0];

    // zero wait states; error only for an unmapped address
    // a status write is dropped quietly, only unmapped words raise an error
    assign PREADY = 1'b1;
    assign PSLVERR = access && !mapped;

    // =========================================================
    // control registers
    logic [2:0] post_div_sel_r;
    logic sync_en_r;
    logic powerdown_r;
    logic spare_r;
    logic doubler_r;
    logic [3:0] cp_code_r;
    logic [2:0] post_div_sel_nxt;
    logic sync_en_nxt;
    logic powerdown_nxt;
    logic spare_nxt;
    logic doubler_nxt;
    logic [3:0] cp_code_nxt;

    // a write replaces the whole byte; other cycles hold the fields
    assign post_div_sel_nxt = wr_a ? PWDATA[POST_DIV_SEL_LSB +: POST_DIV_SEL_W] : post_div_sel_r;
    assign sync_en_nxt = wr_a ? PWDATA[SYNC_EN_BIT] : sync_en_r;
    assign powerdown_nxt = wr_a ? PWDATA[POWERDOWN_BIT] : powerdown_r;
    assign spare_nxt = wr_b ? PWDATA[SPARE_BIT] : spare_r;
    assign doubler_nxt = wr_b ? PWDATA[DOUBLER_BIT] : doubler_r;
    assign cp_code_nxt = wr_b ? PWDATA[CP_CODE_LSB +: CP_CODE_W] : cp_code_r;

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            post_div_sel_r <= RST_POST_DIV_SEL;
            sync_en_r <= RST_SYNC_EN;
            powerdown_r <= RST_POWERDOWN;
        end else begin
            post_div_sel_r <= post_div_sel_nxt;
            sync_en_r <= sync_en_nxt;
            powerdown_r <= powerdown_nxt;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            spare_r <= RST_SPARE;
            doubler_r <= RST_DOUBLER;
            cp_code_r <= RST_CP_CODE;
        end else begin
            spare_r <= spare_nxt;
            doubler_r <= doubler_nxt;
            cp_code_r <= cp_code_nxt;
        end
    end

    // =========================================================
    // calibration sequencer
    locf_cal_if cal_bus ();

    assign cal_bus.powerdown = powerdown_r;
    // a done level left high from before powerdown ends the next calibration at once
    assign cal_bus.cal_done_lvl = pin_lvl[PIN_DONE];

    locf_cal_seq u_cal_seq (
        .clk(SYS_CLK),
        .rst_n(rst_n),
        .cal(cal_bus.seq)
    );

    assign LOOP_ENABLE = cal_bus.loop_enable;
    assign CAL_RESET = cal_bus.cal_reset;
    assign CAL_START = cal_bus.cal_start;

    // =========================================================
    // sync event gating
    logic sync_prev_r;
    logic sync_rise;
    logic resync_r;
    logic resync_nxt;

    // previous level resets low like the idle pin, so reset gives no false edge
    assign sync_rise = pin_lvl[PIN_SYNC] && !sync_prev_r;
    assign resync_nxt = sync_rise && sync_en_r;

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            sync_prev_r <= 1'b0;
            resync_r <= 1'b0;
        end else begin
            sync_prev_r <= pin_lvl[PIN_SYNC];
            resync_r <= resync_nxt;
        end
    end

    assign CHANNEL_RESYNC = resync_r;

    // =========================================================
    // analog control outputs, registered
    logic [4:0] cp_steps_r;
    logic [3:0] post_div_r;
    logic [4:0] cp_steps_nxt;
    logic [3:0] post_div_nxt;

    assign cp_steps_nxt = cp_steps_of(cp_code_r);
    assign post_div_nxt = post_div_of(post_div_sel_r);

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            cp_steps_r <= RST_CP_STEPS;
            post_div_r <= RST_POST_DIV_VAL;
        end else begin
            cp_steps_r <= cp_steps_nxt;
            post_div_r <= post_div_nxt;
        end
    end

    assign REF_DOUBLER_EN = doubler_r;
    assign CP_CODE = cp_code_r;
    assign CP_CURRENT_STEPS = cp_steps_r;
    assign POST_DIV_VALUE = post_div_r;

    // =========================================================
    // read data, captured in the setup cycle
    logic [7:0] rd_a;
    logic [7:0] rd_b;
    logic [7:0] rd_st;
    logic [7:0] rd_sel;
    logic [APB_DW-1:0] prdata_r;
    logic [APB_DW-1:0] prdata_nxt;

    assign rd_a = {3'h0, post_div_sel_r, sync_en_r, powerdown_r};
    assign rd_b = {2'h0, spare_r, doubler_r, cp_code_r};
    assign rd_st = {4'h0, pin_lvl[PIN_SYNC], cal_bus.cal_locked,
                    cal_bus.cal_busy, cal_bus.loop_enable};
    assign rd_sel = hit_a ? rd_a : (hit_b ? rd_b : (hit_st ? rd_st : 8'h00));
    // captured at setup so the word stands settled through the access cycle
    assign prdata_nxt = setup_rd ? {24'h00_0000, rd_sel} : prdata_r;

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            prdata_r <= 32'h0000_0000;
        end else begin
            prdata_r <= prdata_nxt;
        end
    end

    assign PRDATA = prdata_r;
endmodule
`default_nettype wire

// ### verification/locf_chk.sv
// concurrent checks on the loop one control fields top ports
`timescale 1ns/1ps
`default_nettype none
module locf_chk import locf_pkg::*; #(
    parameter int ADDR_WIDTH = locf_pkg::APB_AW
) (
    input wire logic SYS_CLK, // system clock
    input wire logic RESETN, // reset, active low
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb access phase
    input wire logic PWRITE, // apb direction
    input wire logic [ADDR_WIDTH-1:0] PADDR, // apb byte address
    input wire logic [locf_pkg::APB_DW-1:0] PWDATA, // apb write data
    input wire logic [3:0] PSTRB, // apb byte strobes
    input wire logic [locf_pkg::APB_DW-1:0] PRDATA, // apb read data
    input wire logic PREADY, // apb ready
    input wire logic PSLVERR, // apb error
    input wire logic SYNC_EVENT, // sync pin
    input wire logic CAL_DONE, // calibration done pin
    input wire logic CHANNEL_RESYNC, // resync pulse
    input wire logic LOOP_ENABLE, // loop running
    input wire logic CAL_RESET, // calibration held in reset
    input wire logic CAL_START, // calibration start pulse
    input wire logic REF_DOUBLER_EN, // doubler on
    input wire logic [3:0] CP_CODE, // pump gain code
    input wire logic [4:0] CP_CURRENT_STEPS, // pump current steps
    input wire logic [3:0] POST_DIV_VALUE // post divider ratio
);
    // =========================================================
    // decode of powerdown writes
    wire logic ctrl_a_wr;
    wire logic pd_on_wr;
    wire logic pd_off_wr;
    assign ctrl_a_wr = PSEL && PENABLE && PWRITE && PSTRB[0]
        && PADDR == ADDR_WIDTH'({IDX_CTRL_A, 2'b00});
    assign pd_on_wr = ctrl_a_wr && PWDATA[0];
    assign pd_off_wr = ctrl_a_wr && !PWDATA[0];

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);

    // =========================================================
    // assertions
    chk_cp_step_map: assert property (CP_CODE inside {[4'h1:4'h7]} && $stable(CP_CODE)
        && $past(CP_CODE, 2) == CP_CODE |-> CP_CURRENT_STEPS == {1'b0, CP_CODE})
        else $error("pump steps differ from code");
    chk_cp_boost_map: assert property (CP_CODE == 4'h8 && $stable(CP_CODE)
        && $past(CP_CODE, 2) == 4'h8 |-> CP_CURRENT_STEPS == 5'h10)
        else $error("boost code steps wrong");
    chk_div_value_range: assert property (POST_DIV_VALUE inside {[4'h2:4'h8]})
        else $error("post divider ratio out of range");
    chk_pd_stops_loop: assert property (pd_on_wr |-> ##[1:2] (CAL_RESET && !LOOP_ENABLE))
        else $error("powerdown did not stop loop");
    chk_pd_clear_restart: assert property (pd_off_wr && CAL_RESET |-> ##[1:3] CAL_START)
        else $error("calibration not restarted");
    chk_start_pulse_state: assert property (CAL_START |-> LOOP_ENABLE && !CAL_RESET ##1 !CAL_START)
        else $error("bad start pulse");
    chk_reset_holds_off: assert property (CAL_RESET |-> !LOOP_ENABLE && !CAL_START)
        else $error("loop active under calibration reset");
    chk_boot_cal_start: assert property ($rose(RESETN) |-> ##[2:4] CAL_START)
        else $error("no calibration after reset");
    chk_resync_one_cycle: assert property (CHANNEL_RESYNC |=> !CHANNEL_RESYNC)
        else $error("resync pulse too long");

    cov_cal_start: cover property (CAL_START);
    cov_resync: cover property (CHANNEL_RESYNC);
    cov_pd_write: cover property (pd_on_wr);
endmodule
`default_nettype wire

// ### verification/locf_bench.sv
// self-checking bench for the loop one control fields top
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fail_count++; \
    $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module locf_bench;
    import locf_pkg::*;
    localparam logic [11:0] A_CA = {2'b00, IDX_CTRL_A, 2'b00};
    localparam logic [11:0] A_CB = {2'b00, IDX_CTRL_B, 2'b00};
    localparam logic [11:0] A_ST = {2'b00, IDX_STATUS, 2'b00};
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic sync_event = 1'b0;
    logic cal_done = 1'b0;
    logic [31:0] prdata;
    logic [31:0] rdata;
    logic pready, pslverr, rerr, channel_resync, loop_enable, cal_reset, cal_start, ref_doubler_en;
    logic [3:0] cp_code, post_div_value;
    logic [4:0] cp_current_steps;
    int fail_count = 0;
    int compares = 0;
    int starts = 0;
    int pulses = 0;

    locf_top dut (.SYS_CLK(sys_clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .SYNC_EVENT(sync_event), .CAL_DONE(cal_done),
        .CHANNEL_RESYNC(channel_resync), .LOOP_ENABLE(loop_enable), .CAL_RESET(cal_reset),
        .CAL_START(cal_start), .REF_DOUBLER_EN(ref_doubler_en), .CP_CODE(cp_code),
        .CP_CURRENT_STEPS(cp_current_steps), .POST_DIV_VALUE(post_div_value));

    always #2.5 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        if (cal_start === 1'b1) starts++;
        if (channel_resync === 1'b1) pulses++;
    end

    // =========================================================
    // bus helpers
    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d,
        input logic [3:0] st);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= st;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(a, 1'b1, d, 4'hf);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ex, input string nm);
        bus(a, 1'b0, 32'h0, 4'hf);
        `CHK(nm, ex, rdata)
    endtask

    // =========================================================
    // scenarios
    task automatic t_reset();
        rd(A_CA, 32'h1e, "ctrl_a reset");
        rd(A_CB, 32'h18, "ctrl_b reset");
        `CHK("doubler", 1'b1, ref_doubler_en)
        `CHK("cp steps", 5'h10, cp_current_steps)
        `CHK("post div", 4'h8, post_div_value)
        `CHK("boot starts", 1, starts)
        `CHK("loop on", 1'b1, loop_enable)
    endtask

    task automatic t_div();
        for (int c = 0; c < 8; c++) begin
            wr(A_CA, {27'h0, 3'(c), 2'b10});
            `CHK("post div", (c < 2) ? 4'h2 : 4'(c + 1), post_div_value)
        end
    endtask

    task automatic t_cp();
        logic [4:0] ex;
        for (int c = 0; c < 16; c++) begin
            wr(A_CB, {27'h0, c[0], 4'(c)});
            ex = (c == 8) ? 5'h10 : (c >= 1 && c <= 7) ? 5'(c) : 5'h00;
            `CHK("cp code", 4'(c), cp_code)
            `CHK("cp steps", ex, cp_current_steps)
            `CHK("doubler", c[0], ref_doubler_en)
        end
        wr(A_CB, 32'hff);
        rd(A_CB, 32'h3f, "ctrl_b fields");
        // strobe low must leave the byte alone
        bus(A_CB, 1'b1, 32'h0, 4'h0);
        rd(A_CB, 32'h3f, "ctrl_b strobe");
        wr(A_CB, 32'h18);
    endtask

    task automatic t_pd();
        int s0;
        wr(A_CA, 32'h1f);
        `CHK("loop on", 1'b0, loop_enable)
        `CHK("cal reset", 1'b1, cal_reset)
        s0 = starts;
        wr(A_CA, 32'h1e);
        `CHK("restarts", s0 + 1, starts)
        `CHK("loop on", 1'b1, loop_enable)
        `CHK("cal reset", 1'b0, cal_reset)
        cal_done <= 1'b1;
        repeat (8) @(posedge sys_clk);
        rd(A_ST, 32'h5, "status locked");
        cal_done <= 1'b0;
    endtask

    task automatic t_sync();
        int s0;
        for (int e = 1; e >= 0; e--) begin
            wr(A_CA, {27'h0, 3'h7, e[0], 1'b0});
            s0 = pulses;
            sync_event <= 1'b1;
            repeat (10) @(posedge sys_clk);
            rd(A_ST, 32'hd, "status sync pin");
            sync_event <= 1'b0;
            repeat (10) @(posedge sys_clk);
            `CHK("resync pulses", e, pulses - s0)
        end
    endtask

    task automatic t_bus();
        wr(A_ST, 32'hff);
        `CHK("status write err", 1'b0, rerr)
        rd(12'h0e8, 32'h0, "unmapped data");
        `CHK("unmapped err", 1'b1, rerr)
    endtask

    task automatic summarize();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_reset();
        t_div();
        t_cp();
        t_pd();
        t_sync();
        t_bus();
        summarize();
    end

    // well above the roughly 350 cycles the scenarios need
    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        summarize();
    end
endmodule

bind locf_top locf_chk #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SYNC_EVENT(SYNC_EVENT), .CAL_DONE(CAL_DONE), .CHANNEL_RESYNC(CHANNEL_RESYNC),
    .LOOP_ENABLE(LOOP_ENABLE), .CAL_RESET(CAL_RESET), .CAL_START(CAL_START),
    .REF_DOUBLER_EN(REF_DOUBLER_EN), .CP_CODE(CP_CODE), .CP_CURRENT_STEPS(CP_CURRENT_STEPS),
    .POST_DIV_VALUE(POST_DIV_VALUE));
`default_nettype wire
